// ===== bench/lhs_host_model.sv
/*
  Host side model: strobe-dir and separate-strobe buses plus serial shift port.
  Assumes the bench resolves the shared data bus and feeds it back on bus_i.
*/
`timescale 1ns/1ps

module lhs_host_model (
  input wire logic clk_i, // bench clock
  input wire logic [7:0] bus_i, // resolved data bus
  input wire logic dev_oe_n_i, // device drive enable
  input wire logic serial_out_line_i, // device serial out
  output logic data_strobe_n_o, // strobe-dir strobe
  output logic rw_select_o, // high read
  output logic read_strobe_n_o, // separate read strobe
  output logic store_strobe_n_o, // separate write strobe
  output logic [7:0] host_data_o, // host data
  output logic host_oe_n_o, // low while host drives
  output logic shift_clk_o, // shift clock
  output logic select_n_o, // frame select
  output logic serial_in_line_o, // serial data
  output logic edge_select_o // output edge select
);
  initial
  begin
    data_strobe_n_o = 1'b1;
    rw_select_o = 1'b1;
    read_strobe_n_o = 1'b1;
    store_strobe_n_o = 1'b1;
    host_data_o = 8'h00;
    host_oe_n_o = 1'b1;
    shift_clk_o = 1'b0;
    select_n_o = 1'b1;
    serial_in_line_o = 1'b0;
    edge_select_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes held 6 clocks, data held 5 past strobe end to cover the syncs
  task par_io(input logic sep, input logic wr, input logic [7:0] d, output logic [7:0] q,
    output logic oe_seen);
    rw_select_o <= ~wr;
    host_data_o <= d;
    host_oe_n_o <= ~wr;
    @(posedge clk_i);
    if (!sep)
      data_strobe_n_o <= 1'b0;
    else if (wr)
      store_strobe_n_o <= 1'b0;
    else
      read_strobe_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    q = bus_i;
    oe_seen = dev_oe_n_i;
    data_strobe_n_o <= 1'b1;
    read_strobe_n_o <= 1'b1;
    store_strobe_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    host_oe_n_o <= 1'b1;
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // 160 ns shift clock, still outside frames; read bits sampled on opposite edge
  task ser_frame(input logic [7:0] cmd, input logic [7:0] d, input logic fall_edge,
    output logic [7:0] q);
    logic [15:0] bits;
    bits = {cmd, d};
    q = 8'h00;
    edge_select_o <= fall_edge;
    select_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (int i = 0; i < 16; i++)
    begin
      serial_in_line_o <= bits[15-i];
      repeat (10) @(posedge clk_i);
      if (fall_edge && i >= 8)
        q[15-i] = serial_out_line_i;
      shift_clk_o <= 1'b1;
      repeat (10) @(posedge clk_i);
      if (!fall_edge && i >= 8)
        q[15-i] = serial_out_line_i;
      shift_clk_o <= 1'b0;
    end
    repeat (10) @(posedge clk_i);
    select_n_o <= 1'b1;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// ===== bench/tb.sv
/*
  Self-checking bench: Avalon register tasks, host pin model, strap decode.
  Assumes the host model file is compiled first and the design has no params.
*/
`timescale 1ns/1ps
`include "lhs_cfg.svh"

module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ds_n, rw, rd_n, st_n, host_oe_n, sclk, sel_n, sdin, esel, sdout, dev_oe_n;
  logic [7:0] host_data, dev_data;
  wire logic [7:0] bus;
  logic [1:0] c1_loop = 2'h0, c2_loop = 2'h0, c1_pat = 2'h0;
  logic [3:0] c1_prof = 4'h0, c2_prof = 4'h0;
  logic [2:0] c1_mode, c2_mode, c1_tmpl, c2_tmpl;
  logic [1:0] c1_patt, c1_std, c1_imp, c2_std, c2_imp, com_std;
  logic [3:0] prof_t [4] = '{4'h0, 4'h1, 4'h8, 4'h5};
  int mismatches = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [7:0] q;
  logic oe;

  always #4 clk_i = ~clk_i;

  // released bus shows the inverse of the host's last byte, never a stale match
  assign bus = !dev_oe_n ? dev_data : !host_oe_n ? host_data : ~host_data;

  lhs_host_ctl u_lhs_host_ctl (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .parallel_data_strobe_n_i(ds_n), .rw_select_i(rw), .read_strobe_n_i(rd_n),
    .store_strobe_n_i(st_n), .data_bus_i(bus), .data_bus_o(dev_data),
    .data_bus_oe_n_o(dev_oe_n), .shift_clk_i(sclk), .serial_select_n_i(sel_n),
    .serial_in_line_i(sdin), .shift_edge_select_i(esel), .serial_out_line_o(sdout),
    .ch1_loop_select_i(c1_loop), .ch2_loop_select_i(c2_loop),
    .ch1_tx_pattern_select_i(c1_pat), .ch1_line_profile_select_i(c1_prof),
    .ch2_line_profile_select_i(c2_prof), .ch1_loop_mode_o(c1_mode), .ch2_loop_mode_o(c2_mode),
    .ch1_tx_pattern_o(c1_patt), .ch1_line_std_o(c1_std), .ch1_template_o(c1_tmpl),
    .ch1_impedance_o(c1_imp), .ch2_line_std_o(c2_std), .ch2_template_o(c2_tmpl),
    .ch2_impedance_o(c2_imp), .common_line_std_o(com_std));

  lhs_host_model u_lhs_host_model (.clk_i(clk_i), .bus_i(bus), .dev_oe_n_i(dev_oe_n),
    .serial_out_line_i(sdout), .data_strobe_n_o(ds_n), .rw_select_o(rw),
    .read_strobe_n_o(rd_n), .store_strobe_n_o(st_n), .host_data_o(host_data),
    .host_oe_n_o(host_oe_n), .shift_clk_o(sclk), .select_n_o(sel_n),
    .serial_in_line_o(sdin), .edge_select_o(esel));

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    chk32({24'h000000, got}, {24'h000000, exp});
  endtask

  // request held until waitrequest is seen low at a rising edge
  task avs_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_i);
    // only the watchdog ends a wait that never answers
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_i);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // idle edge so a following call never re-raises in this time step
    @(posedge clk_i);
  endtask

  task mem_at(input logic [3:0] p, input logic [7:0] exp);
    avs_xfer(1'b1, `LHS_OFF_PTR, {28'h0000000, p});
    avs_xfer(1'b0, `LHS_OFF_MEMD, 32'h00000000);
    chk8(rd[7:0], exp);
  endtask

  function automatic logic [1:0] std_of(input logic [3:0] p);
    return (p == 4'h0 || p == 4'h1) ? lhs_pkg::LHS_STD_E1 :
      (p == 4'h8) ? lhs_pkg::LHS_STD_J1 : lhs_pkg::LHS_STD_T1;
  endfunction

  function automatic logic [1:0] imp_of(input logic [3:0] p);
    return (p == 4'h0) ? lhs_pkg::LHS_IMP_75 : (p == 4'h1) ? lhs_pkg::LHS_IMP_120 :
      (p == 4'h8) ? lhs_pkg::LHS_IMP_110 : lhs_pkg::LHS_IMP_100;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    complete_run;
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    avs_xfer(1'b0, `LHS_OFF_CTRL, 32'h0);
    chk32(rd, 32'h00000000);
    avs_xfer(1'b0, `LHS_OFF_SWCFG, 32'h0);
    chk32(rd, 32'h00000000);
    avs_xfer(1'b1, 5'h1C, 32'hFFFFFFFF);
    avs_xfer(1'b0, 5'h1C, 32'h0);
    chk32(rd, 32'h00000000);
    $display("test registers done");
    for (int k = 0; k < 4; k++)
    begin
      c1_loop <= 2'(k);
      c2_loop <= 2'(k);
      c1_pat <= 2'(k);
      c1_prof <= prof_t[k];
      c2_prof <= prof_t[(k + 1) % 4];
      repeat (6) @(posedge clk_i);
      chk8(8'(c2_mode), 8'(k));
      chk8(8'(c1_mode), 8'(k));
      chk8(8'(c1_patt), 8'(k));
      chk8({c1_std, c1_imp, 1'b0, c1_tmpl}, {std_of(c1_prof), imp_of(c1_prof), 1'b0, c1_prof[2:0]});
      chk8({c2_std, c2_imp, 1'b0, c2_tmpl}, {std_of(c2_prof), imp_of(c2_prof), 1'b0, c2_prof[2:0]});
      chk8(8'(com_std), 8'(std_of(c1_prof)));
    end
    $display("test straps done");
    avs_xfer(1'b1, `LHS_OFF_CTRL, 32'h1);
    avs_xfer(1'b1, `LHS_OFF_PTR, 32'h3);
    u_lhs_host_model.par_io(1'b0, 1'b1, 8'hA5, q, oe);
    chk8(8'(oe), 8'h01);
    u_lhs_host_model.par_io(1'b0, 1'b0, 8'h00, q, oe);
    chk8(q, 8'hA5);
    chk8(8'(oe), 8'h00);
    chk8(8'(dev_oe_n), 8'h01);
    mem_at(4'h3, 8'hA5);
    avs_xfer(1'b1, `LHS_OFF_SWCFG, 32'h000018BC);
    @(posedge clk_i);
    chk8({c1_mode, c2_mode, c1_patt}, {3'h4, 3'h0, 2'h2});
    chk8({c1_std, c1_imp, c2_std, c2_imp}, {2'h2, 2'h3, 2'h1, 2'h1});
    chk8({c1_tmpl, c2_tmpl, com_std}, {3'h0, 3'h1, 2'h2});
    $display("test strobe-dir done");
    avs_xfer(1'b1, `LHS_OFF_CTRL, 32'h2);
    avs_xfer(1'b1, `LHS_OFF_PTR, 32'h6);
    u_lhs_host_model.par_io(1'b1, 1'b1, 8'h3C, q, oe);
    mem_at(4'h6, 8'h3C);
    u_lhs_host_model.par_io(1'b1, 1'b0, 8'h00, q, oe);
    chk8(q, 8'h3C);
    chk8(8'(oe), 8'h00);
    chk8(8'(dev_oe_n), 8'h01);
    $display("test separate-strobe done");
    avs_xfer(1'b1, `LHS_OFF_CTRL, 32'h3);
    u_lhs_host_model.ser_frame(8'h05, 8'h5A, 1'b0, q);
    mem_at(4'h5, 8'h5A);
    for (int e = 0; e < 2; e++)
    begin
      u_lhs_host_model.ser_frame(8'h86, 8'h00, 1'(e), q);
      chk8(q, 8'h3C);
    end
    u_lhs_host_model.par_io(1'b1, 1'b1, 8'hFF, q, oe);
    chk8(8'(oe), 8'h01);
    u_lhs_host_model.par_io(1'b0, 1'b0, 8'h00, q, oe);
    chk8(8'(oe), 8'h01);
    mem_at(4'h5, 8'h5A);
    avs_xfer(1'b1, `LHS_OFF_CTRL, 32'h1);
    u_lhs_host_model.ser_frame(8'h05, 8'h11, 1'b0, q);
    mem_at(4'h5, 8'h5A);
    avs_xfer(1'b0, `LHS_OFF_STAT, 32'h0);
    chk8(rd[23:16], 8'h03);
    $display("test serial done");
    complete_run;
  end
endmodule

// ===== rtl/lhs_cfg.svh
/*
  Constants of the line interface host and strap control block.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef LHS_CFG_SVH
`define LHS_CFG_SVH

// avalon register map, byte addresses
`define LHS_AVL_AW 5
`define LHS_OFF_CTRL 5'h00
`define LHS_OFF_SWCFG 5'h04
`define LHS_OFF_PTR 5'h08
`define LHS_OFF_MEMD 5'h0C
`define LHS_OFF_STAT 5'h10

// swcfg field positions
`define LHS_SW_C1LOOP 0
`define LHS_SW_C2LOOP 3
`define LHS_SW_C1PAT 6
`define LHS_SW_C1PROF 8
`define LHS_SW_C2PROF 12

// reset values
`define LHS_CTRL_RST 2'h0
`define LHS_SWCFG_RST 16'h0000
`define LHS_PTR_RST 4'h0
`define LHS_PIN_RST 30'h3FFFFFFF

// config space and serial frame
`define LHS_MEM_AW 4
`define LHS_MEM_DW 8
`define LHS_SER_CMD_LAST 5'h07
`define LHS_SER_DAT_LAST 5'h0F
`define LHS_SER_RD_BIT 7

`endif

// ===== rtl/lhs_cfg_mem.sv
/*
  Configuration space memory: one write port, registered read data.
  Assumes a single clock and that the caller arbitrates writers.
*/
`timescale 1ns/1ps
`include "lhs_cfg.svh"

module lhs_cfg_mem (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // async reset, low
  input wire logic we_i, // write enable
  input wire logic [`LHS_MEM_AW-1:0] waddr_i, // write address
  input wire logic [`LHS_MEM_DW-1:0] wdata_i, // write data
  input wire logic [`LHS_MEM_AW-1:0] raddr_i, // read address
  output logic [`LHS_MEM_DW-1:0] rdata_o // read data, one cycle late
);
  logic [`LHS_MEM_DW-1:0] mem [2**`LHS_MEM_AW];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// ===== rtl/lhs_host_ctl.sv
/*
  Host port front end and strap decoder of a dual channel line interface.
  Assumes all pins asynchronous to clk_i; software on an Avalon-MM master.
*/
// Implementation choices: the register offsets and the Avalon-MM register port.
// Functional notes
// - Strobe-dir bus: direction low is a write, high a read.
// - Strobe-dir bus: data strobe captures the bus on writes, drives it on reads.
// - Separate-strobe bus: read data driven only while the read strobe is low.
// - Separate-strobe bus: the store strobe returning high performs a write that captures the bus.
// - The 8-bit data bus is two-way: host drives on writes, device on reads.
// - Serial mode samples the serial input on each rising shift clock edge.
// - Serial output moves on the rising edge when edge select is low, else falling.
// - Hardware mode decodes channel 2 loop select 00 none 01 analog 10 digital 11 remote.
// - Hardware mode never yields in-band loopback; only software can pick it.
// - Channel 1 line profile selects its standard, pulse template and impedance.
// - The common circuitry takes its line standard from channel 1 profile only.
// - Channel 2 line profile selects its standard, pulse template and impedance.
// - Hardware mode decodes channel 1 pattern 00 normal 01 ones 10 prbs 11 off.
`timescale 1ns/1ps
`include "lhs_cfg.svh"

module lhs_host_ctl (
  input wire logic clk_i, // 125 MHz clock
  input wire logic rstn_i, // async reset, low
  input wire logic [`LHS_AVL_AW-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic parallel_data_strobe_n_i, // strobe-dir data strobe
  input wire logic rw_select_i, // high read, low write
  input wire logic read_strobe_n_i, // separate read strobe
  input wire logic store_strobe_n_i, // separate write strobe
  input wire logic [7:0] data_bus_i, // data bus in
  output logic [7:0] data_bus_o, // data bus out
  output logic data_bus_oe_n_o, // low while driving
  input wire logic shift_clk_i, // serial shift clock
  input wire logic serial_select_n_i, // serial frame select
  input wire logic serial_in_line_i, // serial data in
  input wire logic shift_edge_select_i, // output edge select
  output logic serial_out_line_o, // serial data out
  input wire logic [1:0] ch1_loop_select_i, // ch1 loop strap
  input wire logic [1:0] ch2_loop_select_i, // ch2 loop strap
  input wire logic [1:0] ch1_tx_pattern_select_i, // ch1 pattern strap
  input wire logic [3:0] ch1_line_profile_select_i, // ch1 profile strap
  input wire logic [3:0] ch2_line_profile_select_i, // ch2 profile strap
  output logic [2:0] ch1_loop_mode_o, // ch1 loopback
  output logic [2:0] ch2_loop_mode_o, // ch2 loopback
  output logic [1:0] ch1_tx_pattern_o, // ch1 tx pattern
  output logic [1:0] ch1_line_std_o, // ch1 standard
  output logic [2:0] ch1_template_o, // ch1 pulse template
  output logic [1:0] ch1_impedance_o, // ch1 termination
  output logic [1:0] ch2_line_std_o, // ch2 standard
  output logic [2:0] ch2_template_o, // ch2 pulse template
  output logic [1:0] ch2_impedance_o, // ch2 termination
  output logic [1:0] common_line_std_o // shared block standard
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [29:0] pin_raw, pin_meta, pin_sync;
  logic ds_n_s, rw_s, rd_n_s, wr_n_s, sclk_s, csn_s, sin_s, esel_s;
  logic [7:0] d_s;
  logic [1:0] l1_s, l2_s, p1_s;
  logic [3:0] f1_s, f2_s;

  assign pin_raw = {parallel_data_strobe_n_i, rw_select_i, read_strobe_n_i,
    store_strobe_n_i, data_bus_i, shift_clk_i, serial_select_n_i,
    serial_in_line_i, shift_edge_select_i, ch1_loop_select_i,
    ch2_loop_select_i, ch1_tx_pattern_select_i, ch1_line_profile_select_i,
    ch2_line_profile_select_i};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_meta <= `LHS_PIN_RST;
      pin_sync <= `LHS_PIN_RST;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign {ds_n_s, rw_s, rd_n_s, wr_n_s, d_s, sclk_s, csn_s, sin_s, esel_s,
    l1_s, l2_s, p1_s, f1_s, f2_s} = pin_sync;

  // previous synced levels for edge finding
  logic ds_q, wr_q, sclk_q;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ds_q <= 1'b1;
      wr_q <= 1'b1;
      sclk_q <= 1'b1;
    end
    else
    begin
      ds_q <= ds_n_s;
      wr_q <= wr_n_s;
      sclk_q <= sclk_s;
    end
  end

  logic ds_rise, wr_rise, sclk_rise, sclk_fall;
  assign ds_rise = ds_n_s & ~ds_q;
  assign wr_rise = wr_n_s & ~wr_q;
  assign sclk_rise = sclk_s & ~sclk_q;
  assign sclk_fall = ~sclk_s & sclk_q;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave and software registers
  lhs_pkg::lhs_mode_e mode_q;
  logic [15:0] swcfg_q;
  logic [3:0] ptr_q;
  logic [7:0] wr_count_q;
  logic [31:0] next_readdata;
  logic avl_go, avl_mem_we;
  logic [7:0] mem_rdata;
  logic ser_on;

  // write takes effect on the edge the master sees waitrequest low
  assign avl_go = avs_write_i && !avs_waitrequest_o;
  assign avl_mem_we = avl_go && avs_address_i == `LHS_OFF_MEMD;

  always_comb
  begin
    next_readdata = 32'h00000000;
    if (avs_address_i == `LHS_OFF_CTRL)
    begin
      next_readdata[1:0] = mode_q;
    end
    else if (avs_address_i == `LHS_OFF_SWCFG)
    begin
      next_readdata[15:0] = swcfg_q;
    end
    else if (avs_address_i == `LHS_OFF_PTR)
    begin
      next_readdata[3:0] = ptr_q;
    end
    else if (avs_address_i == `LHS_OFF_MEMD)
    begin
      next_readdata[7:0] = mem_rdata;
    end
    else if (avs_address_i == `LHS_OFF_STAT)
    begin
      next_readdata = {8'h00, wr_count_q, 4'h0, ~data_bus_oe_n_o, ser_on,
        common_line_std_o, ch1_tx_pattern_o, ch2_loop_mode_o, ch1_loop_mode_o};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
    begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o <= avs_read_i ? next_readdata : 32'h00000000;
    end
    else
    begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode_q <= lhs_pkg::lhs_mode_e'(`LHS_CTRL_RST);
      swcfg_q <= `LHS_SWCFG_RST;
      ptr_q <= `LHS_PTR_RST;
    end
    else if (avl_go)
    begin
      if (avs_address_i == `LHS_OFF_CTRL)
      begin
        mode_q <= lhs_pkg::lhs_mode_e'(avs_writedata_i[1:0]);
      end
      else if (avs_address_i == `LHS_OFF_SWCFG)
      begin
        swcfg_q <= avs_writedata_i[15:0];
      end
      else if (avs_address_i == `LHS_OFF_PTR)
      begin
        ptr_q <= avs_writedata_i[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parallel host ports
  logic is_sd, is_ss, par_wr, par_rd;
  assign is_sd = mode_q == lhs_pkg::LHS_MODE_STRB_DIR;
  assign is_ss = mode_q == lhs_pkg::LHS_MODE_SEP_STRB;
  // write captured as the strobe ends, data settled by then
  assign par_wr = (is_sd && ds_rise && !rw_s) || (is_ss && wr_rise);
  assign par_rd = (is_sd && !ds_n_s && rw_s) || (is_ss && !rd_n_s);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_bus_oe_n_o <= 1'b1;
      data_bus_o <= 8'h00;
    end
    else
    begin
      data_bus_oe_n_o <= !par_rd;
      data_bus_o <= par_rd ? mem_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial host port: 8 command bits (bit 7 read, 3:0 address), 8 data
  logic [4:0] bit_cnt;
  logic [7:0] in_sh, cmd_q;
  logic [2:0] out_idx;
  logic ser_wr, out_edge;
  assign ser_on = mode_q == lhs_pkg::LHS_MODE_SERIAL && !csn_s;
  assign ser_wr = ser_on && sclk_rise && bit_cnt == `LHS_SER_DAT_LAST
    && !cmd_q[`LHS_SER_RD_BIT];
  assign out_edge = esel_s ? sclk_fall : sclk_rise;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bit_cnt <= 5'h00;
      in_sh <= 8'h00;
      cmd_q <= 8'h00;
    end
    else if (!ser_on)
    begin
      bit_cnt <= 5'h00;
    end
    else if (sclk_rise)
    begin
      in_sh <= {in_sh[6:0], sin_s};
      if (bit_cnt <= `LHS_SER_DAT_LAST)
      begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (bit_cnt == `LHS_SER_CMD_LAST)
      begin
        cmd_q <= {in_sh[6:0], sin_s};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      serial_out_line_o <= 1'b0;
      out_idx <= 3'h0;
    end
    else if (!ser_on)
    begin
      out_idx <= 3'h0;
    end
    else if (out_edge && bit_cnt[4:3] == 2'b01 && cmd_q[`LHS_SER_RD_BIT])
    begin
      serial_out_line_o <= mem_rdata[~out_idx];
      out_idx <= out_idx + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration space
  logic host_we, mem_we;
  logic [7:0] host_wdata, mem_wdata;
  logic [3:0] host_waddr, mem_waddr, mem_raddr;
  // host ports win a same-cycle clash with an avalon write
  assign host_we = par_wr | ser_wr;
  assign host_wdata = ser_wr ? {in_sh[6:0], sin_s} : d_s;
  assign host_waddr = ser_wr ? cmd_q[3:0] : ptr_q;
  assign mem_we = host_we | avl_mem_we;
  assign mem_wdata = host_we ? host_wdata : avs_writedata_i[7:0];
  assign mem_waddr = host_we ? host_waddr : ptr_q;
  assign mem_raddr = ser_on ? cmd_q[3:0] : ptr_q;

  lhs_cfg_mem u_mem (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_count_q <= 8'h00;
    end
    else if (host_we)
    begin
      wr_count_q <= wr_count_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap or software line configuration
  function automatic logic [1:0] prof_std(input logic [3:0] p);
    if (p == 4'h0 || p == 4'h1)
    begin
      prof_std = lhs_pkg::LHS_STD_E1;
    end
    else if (p == 4'h8)
    begin
      prof_std = lhs_pkg::LHS_STD_J1;
    end
    else
    begin
      prof_std = lhs_pkg::LHS_STD_T1;
    end
  endfunction

  function automatic logic [1:0] prof_imp(input logic [3:0] p);
    if (p == 4'h0)
    begin
      prof_imp = lhs_pkg::LHS_IMP_75;
    end
    else if (p == 4'h1)
    begin
      prof_imp = lhs_pkg::LHS_IMP_120;
    end
    else if (p == 4'h8)
    begin
      prof_imp = lhs_pkg::LHS_IMP_110;
    end
    else
    begin
      prof_imp = lhs_pkg::LHS_IMP_100;
    end
  endfunction

  logic is_hw;
  logic [2:0] sw_l1, sw_l2;
  logic [3:0] eff_f1, eff_f2;
  assign is_hw = mode_q == lhs_pkg::LHS_MODE_HW;
  assign sw_l1 = swcfg_q[`LHS_SW_C1LOOP +: 3];
  assign sw_l2 = swcfg_q[`LHS_SW_C2LOOP +: 3];
  assign eff_f1 = is_hw ? f1_s : swcfg_q[`LHS_SW_C1PROF +: 4];
  assign eff_f2 = is_hw ? f2_s : swcfg_q[`LHS_SW_C2PROF +: 4];

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ch1_loop_mode_o <= lhs_pkg::LHS_LOOP_NONE;
      ch2_loop_mode_o <= lhs_pkg::LHS_LOOP_NONE;
      ch1_tx_pattern_o <= lhs_pkg::LHS_PAT_NORMAL;
    end
    else if (is_hw)
    begin
      // two strap bits cannot reach the in-band code
      ch1_loop_mode_o <= {1'b0, l1_s};
      ch2_loop_mode_o <= {1'b0, l2_s};
      ch1_tx_pattern_o <= p1_s;
    end
    else
    begin
      ch1_loop_mode_o <= sw_l1 > lhs_pkg::LHS_LOOP_INBAND ? 3'h0 : sw_l1;
      ch2_loop_mode_o <= sw_l2 > lhs_pkg::LHS_LOOP_INBAND ? 3'h0 : sw_l2;
      ch1_tx_pattern_o <= swcfg_q[`LHS_SW_C1PAT +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ch1_line_std_o <= lhs_pkg::LHS_STD_T1;
      ch1_template_o <= 3'h0;
      ch1_impedance_o <= lhs_pkg::LHS_IMP_75;
      ch2_line_std_o <= lhs_pkg::LHS_STD_T1;
      ch2_template_o <= 3'h0;
      ch2_impedance_o <= lhs_pkg::LHS_IMP_75;
      common_line_std_o <= lhs_pkg::LHS_STD_T1;
    end
    else
    begin
      ch1_line_std_o <= prof_std(eff_f1);
      ch1_template_o <= eff_f1[2:0];
      ch1_impedance_o <= prof_imp(eff_f1);
      ch2_line_std_o <= prof_std(eff_f2);
      ch2_template_o <= eff_f2[2:0];
      ch2_impedance_o <= prof_imp(eff_f2);
      common_line_std_o <= prof_std(eff_f1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_strobe_dir_read: assert property (is_sd && $past(is_sd) && !data_bus_oe_n_o
    |-> $past(!ds_n_s && rw_s)) else $error("strobe-dir drive without read");
  a_sep_read_drive: assert property (is_ss && $past(is_ss) && !data_bus_oe_n_o
    |-> $past(!rd_n_s)) else $error("bus driven with read strobe high");
  a_bus_released: assert property (ser_on || is_hw |=> data_bus_oe_n_o)
    else $error("bus driven outside parallel mode");
  a_strobe_dir_write: assert property (is_sd && ds_rise && !rw_s
    |=> wr_count_q == $past(wr_count_q) + 8'h01) else $error("write not taken");
  a_sep_write_take: assert property (is_ss && wr_rise
    |=> wr_count_q == $past(wr_count_q) + 8'h01) else $error("store not taken");
  a_shift_ignored: assert property (!ser_on |=> bit_cnt == 5'h00)
    else $error("shift clock counted outside serial");
  a_serial_sample: assert property (ser_on && sclk_rise
    |=> in_sh[0] == $past(sin_s)) else $error("serial input not sampled");
  a_out_edge_sel: assert property ($changed(serial_out_line_o)
    |-> $past(esel_s ? sclk_fall : sclk_rise)) else $error("output on wrong edge");
  a_ch2_loop_dec: assert property (is_hw ##1 is_hw
    |-> ch2_loop_mode_o == {1'b0, $past(l2_s)}) else $error("ch2 loop decode");
  a_no_inband_hw: assert property (is_hw
    |=> ch1_loop_mode_o != lhs_pkg::LHS_LOOP_INBAND
    && ch2_loop_mode_o != lhs_pkg::LHS_LOOP_INBAND) else $error("in-band in hw mode");
  a_ch1_pat_dec: assert property (is_hw ##1 is_hw
    |-> ch1_tx_pattern_o == $past(p1_s)) else $error("ch1 pattern decode");
  a_common_std: assert property (common_line_std_o == ch1_line_std_o)
    else $error("common standard not from channel 1");
endmodule

// ===== rtl/lhs_pkg.sv
/*
  Types of the line interface host and strap control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lhs_pkg;
  typedef enum logic [1:0] {
    LHS_MODE_HW = 2'b00,
    LHS_MODE_STRB_DIR = 2'b01,
    LHS_MODE_SEP_STRB = 2'b10,
    LHS_MODE_SERIAL = 2'b11
  } lhs_mode_e;
  typedef enum logic [2:0] {
    LHS_LOOP_NONE = 3'b000,
    LHS_LOOP_ANALOG = 3'b001,
    LHS_LOOP_DIGITAL = 3'b010,
    LHS_LOOP_REMOTE = 3'b011,
    LHS_LOOP_INBAND = 3'b100
  } lhs_loop_e;
  typedef enum logic [1:0] {
    LHS_PAT_NORMAL = 2'b00,
    LHS_PAT_ALL_ONES = 2'b01,
    LHS_PAT_PRBS = 2'b10,
    LHS_PAT_TX_OFF = 2'b11
  } lhs_pat_e;
  typedef enum logic [1:0] {
    LHS_STD_T1 = 2'b00,
    LHS_STD_E1 = 2'b01,
    LHS_STD_J1 = 2'b10
  } lhs_std_e;
  typedef enum logic [1:0] {
    LHS_IMP_75 = 2'b00,
    LHS_IMP_120 = 2'b01,
    LHS_IMP_100 = 2'b10,
    LHS_IMP_110 = 2'b11
  } lhs_imp_e;
endpackage
